// ### common/osc_clock_pkg.sv
package osc_clock_pkg;

  // clock divide select: code n divides the oscillator by 2**n
  localparam int          DIV_SEL_WIDTH     = 3;
  localparam logic [2:0]  DIV_SEL_RESET     = 3'h7;
  localparam int          DIV_COUNT_WIDTH   = 7;

  // trim fields; reset values stand for the factory calibration to the base frequency
  localparam int          TRIM_WIDTH        = 8;
  localparam logic [7:0]  COARSE_TRIM_RESET = 8'h40;
  localparam logic [7:0]  FINE_TRIM_RESET   = 8'h10;
  localparam int          BASE_FREQ_MHZ     = 24;

  // system clock source
  localparam logic        SRC_INTERNAL      = 1'b0;
  localparam logic        SRC_EXTERNAL      = 1'b1;

  // number of port match inputs that can wake the oscillator
  localparam int          PORT_MATCH_COUNT  = 4;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_SUSPEND = 3'b010,
    ST_WAKE    = 3'b100
  } osc_state_t;

  // low-bit mask for divide code n: 2**n - 1
  function automatic logic [6:0] divMask(input logic [2:0] sel);
    logic [6:0] m;
    m = 7'h00;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : divMask

endpackage : osc_clock_pkg

// ### rtl/sysclk_divider.sv
`timescale 1ns/1ps
module sysclk_divider
  import osc_clock_pkg::*;
#(
  parameter int COUNT_WIDTH = DIV_COUNT_WIDTH
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // control
  input  wire logic                     oscRun,
  input  wire logic [DIV_SEL_WIDTH-1:0] divSel,
  // divided clock as a one-cycle tick
  output logic                          sysClkTick
);

  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] mask;

  assign mask = COUNT_WIDTH'(divMask(divSel));

  // counter freezes while the oscillator is halted; the tick is gated by oscRun, so only a tick registered before suspend shows, in its first cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (oscRun) begin
      count_reg <= count_reg + COUNT_WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysClkTick <= 1'b0;
    end else begin
      sysClkTick <= oscRun && ((count_reg & mask) == mask);  // [R2]
    end
  end

endmodule : sysclk_divider

// ### rtl/internal_osc_clock_suspend.sv
`timescale 1ns/1ps
// Function
// R1 - after any reset the system clock source is the internal oscillator.
// R2 - the system clock is the oscillator divided by 1, 2, 4, 8, 16, 32, 64 or 128 per the divide select.
// R3 - the divide select resets to divide by 128.
// R4 - coarse and fine trim settings adjust the oscillator and reset to the base-frequency calibration.
// R5 - writing a one to the suspend bit halts the oscillator.
// R6 - while suspended with the internal source, core and peripheral clocks are gated off.
// R7 - a wake event is any port 0 to 3 match or comparator 0 enabled with a low output.
// R8 - a wake event restarts oscillator, core and peripherals whether or not it interrupts.
// R9 - after waking the core continues at the instruction after the suspend write.
// R10 - the suspend bit clears itself when the wake event restarts the oscillator.
module internal_osc_clock_suspend
  import osc_clock_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // clock divide select write
  input  wire logic                        divSelWrite,
  input  wire logic [DIV_SEL_WIDTH-1:0]    divSelData,
  // trim writes
  input  wire logic                        coarseTrimWrite,
  input  wire logic [TRIM_WIDTH-1:0]       coarseTrimData,
  input  wire logic                        fineTrimWrite,
  input  wire logic [TRIM_WIDTH-1:0]       fineTrimData,
  // clock source select write
  input  wire logic                        sourceWrite,
  input  wire logic                        sourceData,
  // suspend bit write
  input  wire logic                        suspendWrite,
  input  wire logic                        suspendData,
  // wake sources
  input  wire logic [PORT_MATCH_COUNT-1:0] portMatch,
  input  wire logic                        cmp0Enable,
  input  wire logic                        cmp0Out,
  // readback
  output logic [DIV_SEL_WIDTH-1:0]         clock_divide_select,
  output logic [TRIM_WIDTH-1:0]            osc_coarse_trim,
  output logic [TRIM_WIDTH-1:0]            osc_fine_trim,
  output logic                             clockSource,
  output logic                             suspendBit,
  // clock control
  output logic                             oscEnable,
  output logic                             coreClkEnable,
  output logic                             periphClkEnable,
  output logic                             sysClkTick,
  output logic                             coreResume
);

  osc_state_t state_reg;
  osc_state_t state_next;
  logic       wakeEvent;
  logic       gateOff;

  assign wakeEvent = (|portMatch) || (cmp0Enable && !cmp0Out);  // [R7]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_divide_select <= DIV_SEL_RESET;  // [R3]
    end else if (divSelWrite) begin
      clock_divide_select <= divSelData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_coarse_trim <= COARSE_TRIM_RESET;  // [R4]
      osc_fine_trim   <= FINE_TRIM_RESET;  // [R4]
    end else begin
      if (coarseTrimWrite) begin
        osc_coarse_trim <= coarseTrimData;
      end
      if (fineTrimWrite) begin
        osc_fine_trim <= fineTrimData;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clockSource <= SRC_INTERNAL;  // [R1]
    end else if (sourceWrite) begin
      clockSource <= sourceData;
    end
  end

  // a wake already present at the suspend write still suspends for one cycle, then wakes
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (suspendWrite && suspendData) begin
          state_next = ST_SUSPEND;  // [R5]
        end
      end
      ST_SUSPEND: begin
        if (wakeEvent) begin
          state_next = ST_WAKE;  // [R8]
        end
      end
      ST_WAKE: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      suspendBit <= 1'b0;
    end else if (state_next == ST_WAKE) begin
      suspendBit <= 1'b0;  // [R10]
    end else if (state_reg == ST_RUN && suspendWrite) begin
      suspendBit <= suspendData;
    end
  end

  // one-cycle release to the core; it resumes after the suspending write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coreResume <= 1'b0;
    end else begin
      coreResume <= (state_reg == ST_SUSPEND) && wakeEvent;  // [R9]
    end
  end

  assign oscEnable       = (state_reg != ST_SUSPEND);  // [R5] [R8]
  // an external source keeps clocking the core even with the oscillator halted
  assign gateOff         = (state_reg == ST_SUSPEND) && (clockSource == SRC_INTERNAL);  // [R6]
  assign coreClkEnable   = !gateOff;  // [R6]
  assign periphClkEnable = !gateOff;  // [R6]

  sysclk_divider #(
    .COUNT_WIDTH (DIV_COUNT_WIDTH)
  ) divider (
    .clk        (clk),
    .reset_n    (reset_n),
    .oscRun     (oscEnable),
    .divSel     (clock_divide_select),
    .sysClkTick (sysClkTick)
  );

  // helper flags: has the divide select, either trim field or the clock source been written since reset
  logic divWritten_reg;
  logic trimWritten_reg;
  logic srcWritten_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divWritten_reg  <= 1'b0;
      trimWritten_reg <= 1'b0;
      srcWritten_reg  <= 1'b0;
    end else begin
      divWritten_reg  <= divWritten_reg || divSelWrite;
      trimWritten_reg <= trimWritten_reg || coarseTrimWrite || fineTrimWrite;
      srcWritten_reg  <= srcWritten_reg || sourceWrite;
    end
  end

  a_reset_div_128: assert property (  // [R3]
    @(posedge clk) disable iff (!reset_n)
    !divWritten_reg |-> clock_divide_select == 3'h7
  ) else $error("divide select left its reset value without a write");

  a_reset_trim_value: assert property (  // [R4]
    @(posedge clk) disable iff (!reset_n)
    !trimWritten_reg |-> (osc_coarse_trim == COARSE_TRIM_RESET && osc_fine_trim == FINE_TRIM_RESET)
  ) else $error("trim left its calibrated reset value without a write");

  a_reset_source_internal: assert property (  // [R1]
    @(posedge clk) disable iff (!reset_n)
    !srcWritten_reg |-> clockSource == SRC_INTERNAL
  ) else $error("clock source is not internal after reset");

  a_suspend_halts_osc: assert property (  // [R5]
    @(posedge clk) disable iff (!reset_n)
    (state_reg == ST_RUN && suspendWrite && suspendData) |=> !oscEnable && suspendBit
  ) else $error("suspend write did not halt the oscillator");

  a_core_clock_gated: assert property (  // [R6]
    @(posedge clk) disable iff (!reset_n)
    (!oscEnable && clockSource == SRC_INTERNAL) |-> !coreClkEnable && !periphClkEnable
  ) else $error("core or peripheral clock running while suspended");

  a_wake_restarts_osc: assert property (  // [R7]
    @(posedge clk) disable iff (!reset_n)
    (!oscEnable && ((|portMatch) || (cmp0Enable && !cmp0Out))) |=> oscEnable && coreClkEnable ##1 oscEnable
  ) else $error("wake event did not restart the oscillator");

  a_no_wake_stays: assert property (  // [R8]
    @(posedge clk) disable iff (!reset_n)
    (!oscEnable && portMatch == 4'h0 && !(cmp0Enable && !cmp0Out)) |=> !oscEnable && !coreResume
  ) else $error("oscillator restarted without a wake event");

  a_resume_after_wake: assert property (  // [R9]
    @(posedge clk) disable iff (!reset_n)
    $rose(oscEnable) |-> coreResume && !$past(oscEnable)
  ) else $error("core not released when the oscillator restarted");

  a_suspend_self_clear: assert property (  // [R10]
    @(posedge clk) disable iff (!reset_n)
    $rose(oscEnable) |-> !suspendBit
  ) else $error("suspend bit still set after wake");

  a_tick_div_one: assert property (  // [R2]
    @(posedge clk) disable iff (!reset_n)
    (clock_divide_select == 3'h0 && oscEnable) ##1 (clock_divide_select == 3'h0) |-> sysClkTick
  ) else $error("divide by one did not tick every cycle");

  c_suspend_entry: cover property (@(posedge clk) disable iff (!reset_n) $fell(oscEnable));
  c_port_wake: cover property (@(posedge clk) disable iff (!reset_n) !oscEnable && (|portMatch) ##1 coreResume);
  c_cmp_wake: cover property (@(posedge clk) disable iff (!reset_n) !oscEnable && cmp0Enable && !cmp0Out);
  c_external_suspend: cover property (@(posedge clk) disable iff (!reset_n) !oscEnable && coreClkEnable);

endmodule : internal_osc_clock_suspend

// ### dv/internal_osc_clock_suspend_test.sv
`timescale 1ns/1ps
module internal_osc_clock_suspend_test
  import osc_clock_pkg::*;
;
  logic                        clk, reset_n;
  logic                        divSelWrite, coarseTrimWrite, fineTrimWrite, sourceWrite, suspendWrite;
  logic [DIV_SEL_WIDTH-1:0]    divSelData;
  logic [TRIM_WIDTH-1:0]       coarseTrimData, fineTrimData;
  logic                        sourceData, suspendData, cmp0Enable, cmp0Out;
  logic [PORT_MATCH_COUNT-1:0] portMatch;
  logic [DIV_SEL_WIDTH-1:0]    divRb;
  logic [TRIM_WIDTH-1:0]       coarseRb, fineRb;
  logic                        clockSource, suspendBit, oscEnable, coreClkEnable;
  logic                        periphClkEnable, sysClkTick, coreResume;
  int                          miscompares, testsRun;

  internal_osc_clock_suspend dut (
    .clk(clk), .reset_n(reset_n),
    .divSelWrite(divSelWrite), .divSelData(divSelData),
    .coarseTrimWrite(coarseTrimWrite), .coarseTrimData(coarseTrimData),
    .fineTrimWrite(fineTrimWrite), .fineTrimData(fineTrimData),
    .sourceWrite(sourceWrite), .sourceData(sourceData),
    .suspendWrite(suspendWrite), .suspendData(suspendData),
    .portMatch(portMatch), .cmp0Enable(cmp0Enable), .cmp0Out(cmp0Out),
    .clock_divide_select(divRb), .osc_coarse_trim(coarseRb), .osc_fine_trim(fineRb),
    .clockSource(clockSource), .suspendBit(suspendBit), .oscEnable(oscEnable),
    .coreClkEnable(coreClkEnable), .periphClkEnable(periphClkEnable),
    .sysClkTick(sysClkTick), .coreResume(coreResume)
  );

  always #5 clk = ~clk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle strobe: 0 divide, 1 coarse, 2 fine, 3 source, 4 suspend
  task automatic doWrite(input int sel, input logic [7:0] d);
    @(posedge clk);
    case (sel)
      0: begin divSelWrite <= 1'b1; divSelData <= d[2:0]; end
      1: begin coarseTrimWrite <= 1'b1; coarseTrimData <= d; end
      2: begin fineTrimWrite <= 1'b1; fineTrimData <= d; end
      3: begin sourceWrite <= 1'b1; sourceData <= d[0]; end
      default: begin suspendWrite <= 1'b1; suspendData <= d[0]; end
    endcase
    @(posedge clk);
    {divSelWrite, coarseTrimWrite, fineTrimWrite, sourceWrite, suspendWrite} <= 5'h00;
  endtask : doWrite

  task automatic checkReset;
    #1;
    chk(divRb, 32'h7);
    chk(coarseRb, 32'h40);
    chk(fineRb, 32'h10);
    chk(clockSource, 32'h0);
    chk(suspendBit, 32'h0);
    chk(oscEnable, 32'h1);
  endtask : checkReset

  // bounded waits: a missing tick runs out the count and ends the run
  task automatic measure(input int n);
    int cnt;
    cnt = 0;
    // start past the loading edge so a tick left from the old divide is not counted
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (sysClkTick !== 1'b1 && cnt < 300);
    if (cnt >= 300) begin
      miscompares++;
      end_sim();
    end
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (sysClkTick !== 1'b1 && cnt < 300);
    chk(cnt, 32'h1 << n);
    if (cnt >= 300) end_sim();
  endtask : measure

  // src 0..3 port match, 4 comparator; ext tells whether the source is external
  task automatic suspendWake(input int src, input logic ext);
    doWrite(4, 8'h01);
    #1;
    chk(oscEnable, 32'h0);
    chk(suspendBit, 32'h1);
    chk(coreClkEnable, ext);
    chk(periphClkEnable, ext);
    @(posedge clk);
    cmp0Enable <= 1'b1;
    cmp0Out <= 1'b1;
    #1;
    chk(oscEnable, 32'h0);
    @(posedge clk);
    cmp0Enable <= (src == 4);
    cmp0Out <= (src != 4);
    portMatch <= (src < 4) ? (PORT_MATCH_COUNT'(1) << src) : '0;
    #1;
    chk(oscEnable, 32'h0);
    chk(sysClkTick, 32'h0);
    @(posedge clk);
    portMatch <= '0;
    cmp0Enable <= 1'b0;
    cmp0Out <= 1'b0;
    #1;
    chk(oscEnable, 32'h1);
    chk(coreClkEnable, 32'h1);
    chk(periphClkEnable, 32'h1);
    chk(suspendBit, 32'h0);
    chk(coreResume, 32'h1);
    @(posedge clk);
    #1;
    chk(coreResume, 32'h0);
  endtask : suspendWake

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {divSelWrite, coarseTrimWrite, fineTrimWrite, sourceWrite, suspendWrite} = 5'h00;
    {divSelData, coarseTrimData, fineTrimData, sourceData, suspendData} = '0;
    {portMatch, cmp0Enable, cmp0Out} = '0;
    miscompares = 0;
    testsRun = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    checkReset();
    measure(7);
    for (int n = 0; n < 8; n++) begin
      doWrite(0, n[7:0]);
      #1;
      chk(divRb, n);
      measure(n);
    end
    doWrite(1, 8'hA5);
    doWrite(2, 8'h3C);
    #1;
    chk(coarseRb, 32'hA5);
    chk(fineRb, 32'h3C);
    doWrite(0, 8'h00);
    // writing zero in run state must leave everything running
    doWrite(4, 8'h00);
    #1;
    chk(oscEnable, 32'h1);
    for (int s = 0; s < 5; s++) suspendWake(s, 1'b0);
    doWrite(3, 8'h01);
    #1;
    chk(clockSource, 32'h1);
    suspendWake(0, 1'b1);
    // reset in mid-run must bring the internal source back
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    checkReset();
    end_sim();
  end
endmodule : internal_osc_clock_suspend_test
